// ==== include/pat_defs.vh ====
// Register map, reset values and port codes of the arbitration table block
`ifndef PAT_DEFS_VH
`define PAT_DEFS_VH

`define PAT_ADDR_W          12
`define PAT_OFF_TBL0        12'h220
`define PAT_OFF_TBL1        12'h224
`define PAT_OFF_TBL2        12'h228
`define PAT_OFF_CTL         12'h214
`define PAT_OFF_STS         12'h218
`define PAT_LOAD_BIT        16
`define PAT_DIRTY_BIT       0
`define PAT_RST_TBL0        32'h1765_4321
`define PAT_RST_TBL1        32'h2176_5432
`define PAT_RST_TBL2        32'h3217_6543
`define PAT_PORT_UP         4'h0
`define PAT_PORT_DN_LO      4'h2
`define PAT_PORT_DN_HI      4'h5
`define PAT_NUM_PHASES      24
`define PAT_LOAD_CYCLES     5'h18

`endif

// ==== hw/pat_table.v ====
// Port arbitration table, phases 0 to 23, with load and working copy
`timescale 1ns/1ps
`include "pat_defs.vh"
// Operation
// [RULE1] Four-bit phase fields, eight per word
// [RULE2] Phase words at 0x220, 0x224, 0x228
// [RULE3] Codes 0x0, 0x2-0x5 name ports
// [RULE4] Codes 0x6 to 0xF are reserved
// [RULE5] Invalid entries skipped with no delay
// [RULE6] Software avoids reserved and egress codes
// [RULE7] Reset phases 0-7: 1,2,3,4,5,6,7,1
// [RULE8] Reset phases 8-15: 2,3,4,5,6,7,1,2
// [RULE9] Reset phases 16-23: 3,4,5,6,7,1,2,3
// [RULE10] Phase fields read back last written
// [RULE11] Load bit copies table, reads zero
// [RULE12] Dirty set on write, cleared after load
// [RULE13] Load and dirty only on upstream port
module pat_table #(
	parameter EGRESS_PORT = 4'h0
) (
	input  wire                     clk,
	input  wire                     reset,
	input  wire                     clk_en,
	input  wire                     is_upstream,
	input  wire [`PAT_ADDR_W-1:0]   addr,
	input  wire [31:0]              wdata,
	input  wire                     wr,
	input  wire                     rd,
	input  wire                     arb_advance,
	output reg  [31:0]              rdata,
	output reg                      arb_valid,
	output reg  [3:0]               arb_port,
	output reg  [4:0]               arb_phase,
	output reg                      arb_dirty
);

////////////////////////////////////////////////////////////////////////////////

	// A code names a usable ingress port: upstream or a downstream port, not egress
	function valid_port;
		input [3:0] code;
		begin
			valid_port = ((code == `PAT_PORT_UP) ||                               // RULE3
				((code >= `PAT_PORT_DN_LO) && (code <= `PAT_PORT_DN_HI))) &&  // RULE4
				(code != EGRESS_PORT);
		end
	endfunction

	function [3:0] field;
		input [95:0] tbl;
		input [4:0]  ph;
		begin
			field = tbl[{ph, 2'b00} +: 4]; // RULE1
		end
	endfunction

	reg  [31:0] tbl_q [0:2];
	reg  [95:0] work_q;
	reg         load_q;
	reg  [4:0]  load_cnt_q;
	reg  [4:0]  ph_q;
	integer     i;

	wire [1:0]  wsel  = (addr == `PAT_OFF_TBL0) ? 2'd0 :
		(addr == `PAT_OFF_TBL1) ? 2'd1 : 2'd2;
	wire        tbl_hit = (addr == `PAT_OFF_TBL0) || (addr == `PAT_OFF_TBL1) ||
		(addr == `PAT_OFF_TBL2); // RULE2
	wire        load_req = wr && (addr == `PAT_OFF_CTL) && wdata[`PAT_LOAD_BIT] &&
		is_upstream; // RULE13

////////////////////////////////////////////////////////////////////////////////

	// Table storage and loading into the working copy
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tbl_q[0]   <= `PAT_RST_TBL0; // RULE7
			tbl_q[1]   <= `PAT_RST_TBL1; // RULE8
			tbl_q[2]   <= `PAT_RST_TBL2; // RULE9
			work_q     <= {`PAT_RST_TBL2, `PAT_RST_TBL1, `PAT_RST_TBL0};
			load_q     <= 1'b0;
			load_cnt_q <= 5'h00;
			arb_dirty  <= 1'b0;
		end else if (clk_en) begin
			if (wr && tbl_hit)
				tbl_q[wsel] <= wdata; // RULE10
			if (load_req && !load_q) begin
				load_q     <= 1'b1; // RULE11
				load_cnt_q <= 5'h00;
			end else if (load_q) begin
				// One phase copied per cycle; a write during the copy restarts nothing
				work_q[{load_cnt_q, 2'b00} +: 4] <=
					field({tbl_q[2], tbl_q[1], tbl_q[0]}, load_cnt_q);
				if (load_cnt_q == `PAT_LOAD_CYCLES - 5'h01)
					load_q <= 1'b0;
				else
					load_cnt_q <= load_cnt_q + 5'h01;
			end
			// Set on a table write wins over the clear at load end
			if (!is_upstream)
				arb_dirty <= 1'b0; // RULE13
			else if (wr && tbl_hit)
				arb_dirty <= 1'b1; // RULE12
			else if (load_q && (load_cnt_q == `PAT_LOAD_CYCLES - 5'h01))
				arb_dirty <= 1'b0; // RULE12
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Register read port, data one cycle after the strobe
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			rdata <= 32'h0000_0000;
			if (rd) begin
				if (tbl_hit)
					rdata <= tbl_q[wsel]; // RULE10
				else if (addr == `PAT_OFF_STS)
					rdata <= {31'h0000_0000, arb_dirty & is_upstream}; // RULE13
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Phase walker: find the next valid entry at or after the start phase
	reg  [4:0] scan;
	reg  [4:0] nxt;
	reg        found;
	always @* begin
		nxt   = ph_q;
		found = 1'b0;
		scan  = ph_q;
		for (i = 0; i < `PAT_NUM_PHASES; i = i + 1) begin
			if (!found && valid_port(field(work_q, scan))) begin
				found = 1'b1; // RULE5
				nxt   = scan;
			end
			scan = (scan == 5'd23) ? 5'd0 : scan + 5'd1;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ph_q      <= 5'h00;
			arb_valid <= 1'b0;
			arb_port  <= 4'h0;
			arb_phase <= 5'h00;
		end else if (clk_en) begin
			arb_valid <= found && !load_q;
			arb_port  <= field(work_q, nxt);
			arb_phase <= nxt;
			if (arb_advance && found)
				ph_q <= (nxt == 5'd23) ? 5'd0 : nxt + 5'd1; // RULE5
			else
				ph_q <= nxt;
		end
	end

endmodule // pat_table

// ==== test/pat_checker.sv ====
// Port assertions of the arbitration table
`timescale 1ns/1ps
module pat_checker(
	input wire clk,reset,clk_en,is_upstream,wr,rd,arb_advance,arb_valid,arb_dirty,
	input wire [11:0] addr,input wire [31:0] wdata,rdata,input wire [3:0] arb_port,
	input wire [4:0] arb_phase);
default clocking @(posedge clk); endclocking
default disable iff (reset);
sequence s_load; clk_en&&wr&&addr==12'h214&&wdata[16]&&is_upstream&&arb_valid; endsequence
a_tbl_dirty: assert property (clk_en&&wr&&is_upstream&&addr[11:4]==8'h22&&addr[3:2]!=3
	&&addr[1:0]==0|=>arb_dirty) else $error("dirty");
a_ctl_zero: assert property (clk_en&&rd&&addr==12'h214|=>rdata==0) else $error("ctl");
a_sts_bits: assert property (clk_en&&rd&&addr==12'h218|=>rdata[31:1]==0)
	else $error("sts");
a_down_clean: assert property (!is_upstream&&clk_en|=>!arb_dirty) else $error("down");
a_load_hide: assert property (s_load|=>##1 !arb_valid[*8]) else $error("hide");
a_load_end: assert property (s_load|->##[1:30] !arb_dirty) else $error("end");
a_port_legal: assert property (arb_valid|->arb_port inside {[4'h2:4'h5]})
	else $error("port");
a_phase_max: assert property (arb_phase<5'd24) else $error("phase");
endmodule // pat_checker
bind pat_table pat_checker u_pat_checker(.clk(clk),.reset(reset),.clk_en(clk_en),
	.is_upstream(is_upstream),.wr(wr),.rd(rd),.arb_advance(arb_advance),
	.arb_valid(arb_valid),.arb_dirty(arb_dirty),.addr(addr),.wdata(wdata),.rdata(rdata),
	.arb_port(arb_port),.arb_phase(arb_phase));

// ==== test/pat_table_tb.sv ====
// Self-checking bench of the arbitration table
`timescale 1ns/1ps
`define CHK(a,e) begin total_checks++; if((a)!==(e)) begin errors++; \
	$display("MISMATCH %0t %h %h",$time,a,e); end end
module pat_table_tb;
reg clk=0,reset=1,clk_en=1,is_upstream=1,wr=0,rd=0,arb_advance=0,pend=0;
reg [11:0] addr=0;
reg [31:0] wdata=0,s=32'hb92e,e,x;
wire [31:0] rdata;
wire arb_valid,arb_dirty;
wire [3:0] arb_port;
wire [4:0] arb_phase;
int errors=0,total_checks=0,i;
reg [31:0] q[$];
reg [31:0] t[0:2];
reg [95:0] wk={32'h32176543,32'h21765432,32'h17654321};
always #25 clk=~clk;
pat_table u_pat_table(.clk(clk),.reset(reset),.clk_en(clk_en),.is_upstream(is_upstream),
	.addr(addr),.wdata(wdata),.wr(wr),.rd(rd),.arb_advance(arb_advance),.rdata(rdata),
	.arb_valid(arb_valid),.arb_port(arb_port),.arb_phase(arb_phase),.arb_dirty(arb_dirty));
function [31:0] xs(input [31:0] v);
	v^=v<<13;
	v^=v>>17;
	return v^(v<<5);
endfunction
task w(input [11:0] a,input [31:0] d);
	@(posedge clk) {wr,rd,addr,wdata}<={2'b10,a,d};
endtask
task r(input [11:0] a,input [31:0] d);
	@(posedge clk) {wr,rd,addr}<={2'b01,a};
	q.push_back(d);
endtask
task n;
	@(posedge clk) {wr,rd}<=2'b00;
endtask
task final_report;
	$display("checks %0d errors %0d",total_checks,errors);
	if(errors==0&&total_checks>0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
always @(posedge clk) begin
	arb_advance<=~arb_advance;
	if(pend) begin
		e=q.pop_front();
		`CHK(rdata,e)
	end
	if(arb_valid) begin
		`CHK(arb_port,wk[arb_phase*4+:4])
		`CHK(arb_port>=4'h2&&arb_port<=4'h5,1'b1)
	end
	pend<=rd;
end
initial begin
	repeat(20) @(posedge clk);
	reset<=0;
	r(12'h220,32'h17654321);
	r(12'h224,32'h21765432);
	r(12'h228,32'h32176543);
	r(12'h22c,0);
	$display("reset test done");
	for(i=0;i<3;i++) begin
		s=xs(s);
		x=(s&32'h33333333)+32'h22222222;
		t[i]=x;
		w(12'h220+4*i,x);
		r(12'h220+4*i,x);
	end
	r(12'h218,1);
	w(12'h214,32'h10000);
	r(12'h214,0);
	n;
	for(i=0;i<40&&arb_dirty;i++) @(negedge clk);
	if(i==40) begin
		errors++;
		final_report;
	end
	wk={t[2],t[1],t[0]};
	r(12'h218,0);
	r(12'h228,x);
	$display("load test done");
	n;
	@(posedge clk) is_upstream<=0;
	w(12'h220,x);
	r(12'h218,0);
	r(12'h220,x);
	n;
	@(posedge clk) clk_en<=0;
	w(12'h224,0);
	n;
	@(posedge clk) clk_en<=1;
	r(12'h224,t[1]);
	n;
	repeat(3) @(posedge clk);
	$display("downstream test done");
	final_report;
end
endmodule // pat_table_tb
